/* File: bench/svm_far_end.sv */
// Far-end slot taker: the trail termination side of the source slot stream.
// Assumes the mapper's source slot port; pace 0 prompt, 1 slow, 2 halted.
`timescale 1ns/10ps
`default_nettype none
module svm_far_end
  import svm_pkg::*;
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_nrst,
  // Slot stream and strobes from the mapper
  input  wire svm_slot_s  i_slot,
  input  wire logic       i_valid,
  input  wire logic       i_idle,
  input  wire logic       i_psi,
  input  wire logic       i_fs,
  output logic            o_ready,
  // Pace chosen by the bench
  input  wire logic [1:0] i_mode
);
  logic [69:0] got[$];

  // Slow pace drops ready every other cycle so slots must stand
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      o_ready <= 1'b0;
    else
      o_ready <= (i_mode == 2'h0) | ((i_mode == 2'h1) & ~o_ready);
  end

  // Each accepted slot is logged with its idle, marker and frame-start strobes
  always @(posedge i_core_clk)
  begin
    if (i_nrst && i_valid === 1'b1 && o_ready)
      got.push_back({i_idle, i_psi, i_fs, i_slot});
  end
endmodule
`default_nettype wire

/* File: bench/test_sdh_vc_section_slot_mapper.sv */
// Testbench of the VC section/slot mapper: source framing and sink unpacking.
// Assumes the mapper sources and the far-end model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_sdh_vc_section_slot_mapper
  import svm_pkg::*;
;
  logic        i_core_clk = 1'b0;
  logic        i_nrst     = 1'b0;
  svm_oct_s    oct        = '0;
  svm_slot_s   kslot      = '0;
  svm_slot_s   slot;
  logic        sval = 1'b0, vc3 = 1'b0, kval = 1'b0, kvc3 = 1'b0, okr = 1'b0;
  logic        src_rdy, svalid, sready, kready, st_idle, st_psi, st_fs;
  logic        ovalid, ffirst, locked;
  logic [3:0]  order = 4'h1;
  logic [1:0]  idle  = 2'h0;
  logic [1:0]  mode  = 2'h0;
  logic [7:0]  octet;
  logic [23:0] align;
  logic [3:0]  seg;
  logic [8:0]  sq[$];
  int          err_total   = 0;
  int          checks_done = 0;

  always #5 i_core_clk = ~i_core_clk;

  svm_mapper dut (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_src_octet(oct), .i_src_valid(sval), .o_src_ready(src_rdy),
    .i_src_vc3(vc3), .i_src_order(order), .i_idle_count(idle),
    .o_adapted_slot_data(slot), .o_slot_valid(svalid), .i_slot_ready(sready),
    .o_idle_insert_strobe(st_idle), .o_perf_supervision_insert_strobe(st_psi),
    .o_frame_start_strobe(st_fs), .i_sink_slot(kslot), .i_sink_valid(kval),
    .o_sink_ready(kready), .i_sink_vc3(kvc3), .o_sink_octet(octet),
    .o_sink_octet_valid(ovalid), .i_sink_octet_ready(okr),
    .o_sink_frame_first(ffirst), .o_sink_align(align), .o_sink_segment(seg),
    .o_sink_locked(locked)
  );

  svm_far_end far (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_slot(slot), .i_valid(svalid),
    .i_idle(st_idle), .i_psi(st_psi), .i_fs(st_fs), .o_ready(sready), .i_mode(mode)
  );

  // Octet consumer stalls every other cycle
  always @(posedge i_core_clk)
  begin
    okr <= ~okr;
    if (ovalid === 1'b1 && okr === 1'b1)
      sq.push_back({ffirst, octet});
  end

  task automatic cmp(input logic [69:0] got, input logic [69:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [63:0] pack(input int n, input int o, input logic [7:0] base);
    logic [63:0] ex;
    ex = '0;
    for (int i = 0; i < n; i++)
      ex = {ex[55:0], base + 8'(o + i)};
    return ex;
  endfunction

  // Called just after a rising edge; holds each octet until taken
  task automatic send(input int n, input logic [7:0] base);
    int t;
    for (int i = 0; i < n; i++)
    begin
      oct <= '{sof: (i == 0), d: base + 8'(i)};
      sval <= 1'b1;
      t = 0;
      do
      begin
        @(negedge i_core_clk);
        t++;
      end
      while (src_rdy !== 1'b1 && t < 400);
      @(posedge i_core_clk);
    end
    sval <= 1'b0;
  endtask

  // Same edge rules for the sink slot, with a dead cycle after each
  task automatic put(input svm_kind_e kd, input logic f, input logic [63:0] d);
    kslot <= '{kind: kd, fs: f, data: d};
    kval <= 1'b1;
    for (int t = 0; t < 100; t++)
    begin
      @(negedge i_core_clk);
      if (kready === 1'b1)
        break;
    end
    @(posedge i_core_clk);
    kval <= 1'b0;
    @(posedge i_core_clk);
  endtask

  task automatic slot_is(input int k, input logic [2:0] sb, input svm_kind_e kd,
                         input logic [63:0] d);
    logic [69:0] w;
    w = far.got[k];
    cmp(w, {sb, kd, sb[0], d});
  endtask

  task automatic frame(input logic v3, input logic [3:0] x, input logic [1:0] ni,
                       input logic [7:0] base, input logic [1:0] pace);
    int segs;
    int nid;
    int n;
    int k;
    int o;
    logic [63:0] ex;
    segs = (v3 || x == 4'h0) ? 1 : int'(x);
    nid = (ni > 2'h2) ? 2 : int'(ni);
    n = nid + segs * 295;
    @(posedge i_core_clk);
    far.got.delete();
    vc3 <= v3;
    order <= x;
    idle <= ni;
    mode <= pace;
    @(posedge i_core_clk);
    fork
      send(v3 ? 2351 : 2349 * segs, base);
      if (pace == 2'h2)
      begin
        repeat (100) @(negedge i_core_clk);
        cmp(70'(src_rdy), 70'h0);
        @(posedge i_core_clk);
        mode <= 2'h1;
      end
    join
    for (int t = 0; t < 3000 && far.got.size() < n; t++)
      @(negedge i_core_clk);
    cmp(70'(far.got.size()), 70'(n));
    for (int j = 0; j < nid; j++)
      slot_is(j, 3'h4, SVM_K_IDLE, 64'h0);
    k = nid;
    o = 0;
    for (int s = 0; s < segs; s++)
    begin
      slot_is(k, {1'b0, 1'b1, s == 0}, SVM_K_PS, 64'h0);
      ex = pack(v3 ? 7 : 5, o, base);
      if (v3)
        ex[63:56] = 8'hc3;
      else
        ex[63:40] = {8'hc3, 12'h000, 4'(s)};
      slot_is(k + 1, 3'h0, SVM_K_INIT, ex);
      o += v3 ? 7 : 5;
      for (int j = 0; j < 293; j++)
      begin
        slot_is(k + 2 + j, 3'h0, SVM_K_DATA, pack(8, o, base));
        o += 8;
      end
      k += 295;
    end
    cmp(70'(src_rdy), 70'h1);
    $display("frame test done, vc3 %0d order %0d idles %0d", v3, x, ni);
  endtask

  task automatic sink_run(input logic v3);
    logic [63:0] d;
    int          ni;
    int          no;
    ni = v3 ? 7 : 5;
    no = ni + 293 * 8;
    @(posedge i_core_clk);
    kvc3 <= v3;
    sq.delete();
    put(SVM_K_PS, 1'b1, 64'h0);
    put(SVM_K_IDLE, 1'b0, 64'h0);
    d = pack(ni, 0, 8'h40);
    if (v3)
      d[63:56] = 8'hc3;
    else
      d[63:40] = 24'hc30000;
    put(SVM_K_INIT, 1'b0, d);
    for (int j = 0; j < 293; j++)
      put(SVM_K_DATA, 1'b0, pack(8, ni + 8 * j, 8'h40));
    for (int t = 0; t < 100 && sq.size() < no; t++)
      @(negedge i_core_clk);
    cmp(70'(sq.size()), 70'(no));
    for (int j = 0; j < sq.size(); j++)
      cmp(70'(sq[j]), {61'h0, j == 0, 8'h40 + 8'(j)});
    cmp(70'({align, seg, locked}), 70'({(v3 ? 24'h0000c3 : 24'hc30000), 4'h0, 1'b1}));
    $display("sink test done, vc3 %0d octets %0d", v3, sq.size());
  endtask

  initial
  begin
    repeat (2) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    frame(1'b0, 4'h0, 2'h3, 8'h00, 2'h2);
    frame(1'b0, 4'h2, 2'h0, 8'h11, 2'h1);
    frame(1'b1, 4'h1, 2'h1, 8'h22, 2'h0);
    sink_run(1'b0);
    sink_run(1'b1);
    conclude();
  end

  // Whole run needs about 20000 cycles
  initial
  begin
    repeat (60000) @(posedge i_core_clk);
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire

/* File: src/svm_defs.svh */
// Constants of the VC section/slot mapper: sizes, counts and tags.
// Assumes inclusion by the mapper module source, the only file that uses these macros.
`ifndef SVM_DEFS_SVH
`define SVM_DEFS_SVH
`define SVM_SEG_OCTETS 12'h92d
`define SVM_DATA_SLOTS 9'h125
`define SVM_LAST_DATA  9'h124
`define SVM_VC4_INIT   4'h5
`define SVM_VC3_INIT   4'h7
`define SVM_SLOT_OCT   4'h8
`define SVM_MAX_IDLE   2'h2
`define SVM_ALIGN_TAG  8'hc3
`define SVM_FIFO_DEPTH 16
`define SVM_OCT_W      9
`endif

/* File: src/svm_mapper.sv */
// VC-4/VC-4-Xc/VC-3 section to channel slot mapper, source and sink.
// Assumes one clock; octet and slot partners honour valid/ready.
`timescale 1ns/10ps
`default_nettype none
`include "svm_defs.svh"

module svm_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_nrst,
  // Fill side
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_ready,
  // Drain side
  output logic [W-1:0]      o_data,
  output logic              o_valid,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign o_ready = (cnt_q != D[AW:0]);
  assign o_valid = (cnt_q != '0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem_q[rp_q];

  always_ff @(posedge i_core_clk)
  begin
    if (push)
    begin
      mem_q[wp_q] <= i_data;
    end
  end

  // Depth is a power of two, so pointers wrap on their own
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

module svm_mapper
  import svm_pkg::*;
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_nrst,
  // Source octet stream
  input  wire svm_oct_s   i_src_octet,
  input  wire logic       i_src_valid,
  output logic            o_src_ready,
  // Source mode and justification
  input  wire logic       i_src_vc3,
  input  wire logic [3:0] i_src_order,
  input  wire logic [1:0] i_idle_count,
  // Source slot stream and strobes
  output svm_slot_s       o_adapted_slot_data,
  output logic            o_slot_valid,
  input  wire logic       i_slot_ready,
  output logic            o_idle_insert_strobe,
  output logic            o_perf_supervision_insert_strobe,
  output logic            o_frame_start_strobe,
  // Sink slot stream
  input  wire svm_slot_s  i_sink_slot,
  input  wire logic       i_sink_valid,
  output logic            o_sink_ready,
  input  wire logic       i_sink_vc3,
  // Sink octet stream, alignment, segment and lock status
  output logic [7:0]      o_sink_octet,
  output logic            o_sink_octet_valid,
  input  wire logic       i_sink_octet_ready,
  output logic            o_sink_frame_first,
  output logic [23:0]     o_sink_align,
  output logic [3:0]      o_sink_segment,
  output logic            o_sink_locked
);
  function automatic logic [3:0] svm_init_len(input logic vc3);
    return vc3 ? `SVM_VC3_INIT : `SVM_VC4_INIT;
  endfunction

  svm_src_e    st_q;
  svm_oct_s    f_data;
  logic        f_valid;
  logic        f_ready;
  logic [3:0]  cnt_q;
  logic [3:0]  need;
  logic [3:0]  seg_q;
  logic [3:0]  segs_q;
  logic        vc3_q;
  logic [1:0]  idle_q;
  logic [1:0]  ic_q;
  logic [8:0]  dcnt_q;
  logic [63:0] acc_q;
  svm_slot_s   slot_q;
  svm_slot_s   nslot;
  logic        ov_q;
  logic        out_free;
  logic        acc_go;
  logic        restart;
  logic        emit;
  logic        sof_seen;

  // Octets wait here while idle and marker slots go out
  svm_fifo #(.W(`SVM_OCT_W), .D(`SVM_FIFO_DEPTH)) u_fifo (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_data     (i_src_octet),
    .i_valid    (i_src_valid),
    .o_ready    (o_src_ready),
    .o_data     (f_data),
    .o_valid    (f_valid),
    .i_ready    (f_ready)
  );

  assign out_free = !ov_q || i_slot_ready;
  assign sof_seen = (st_q == SVM_S_WAIT) && f_valid && f_data.sof;

  always_comb
  begin
    need    = (st_q == SVM_S_INIT) ? svm_init_len(vc3_q) : `SVM_SLOT_OCT;
    acc_go  = ((st_q == SVM_S_INIT) || (st_q == SVM_S_DATA)) && (cnt_q < need);
    // An unexpected frame start aborts the section and relocks
    restart = acc_go && f_valid && f_data.sof &&
              !((st_q == SVM_S_INIT) && (seg_q == 4'h0) && (cnt_q == 4'h0));
    f_ready = (st_q == SVM_S_WAIT) ? !f_data.sof : (acc_go && !restart);
    emit    = 1'b0;
    nslot   = '0;
    case (st_q)
      SVM_S_JUST:
      begin
        emit       = out_free && (idle_q != 2'h0);
        nslot.kind = SVM_K_IDLE;
      end
      SVM_S_PSI:
      begin
        emit       = out_free;
        nslot.kind = SVM_K_PS;
        nslot.fs   = (seg_q == 4'h0);
      end
      SVM_S_INIT:
      begin
        emit       = out_free && (cnt_q == need);
        nslot.kind = SVM_K_INIT;
        if (vc3_q)
          nslot.data = {`SVM_ALIGN_TAG, acc_q[55:0]};
        else
          nslot.data = {`SVM_ALIGN_TAG, 12'h000, seg_q, acc_q[39:0]};
      end
      SVM_S_DATA:
      begin
        emit       = out_free && (cnt_q == `SVM_SLOT_OCT);
        nslot.kind = SVM_K_DATA;
        nslot.data = acc_q;
      end
      default:
      begin
        emit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      st_q <= SVM_S_WAIT;
    else
    begin
      case (st_q)
        SVM_S_WAIT:
          if (sof_seen)
            st_q <= SVM_S_JUST;
        SVM_S_JUST:
          if (idle_q == 2'h0)
            st_q <= SVM_S_PSI;
        SVM_S_PSI:
          if (emit)
            st_q <= SVM_S_INIT;
        SVM_S_INIT:
          if (restart)
            st_q <= SVM_S_WAIT;
          else if (emit)
            st_q <= SVM_S_DATA;
        SVM_S_DATA:
          if (restart)
            st_q <= SVM_S_WAIT;
          else if (emit && (dcnt_q == `SVM_LAST_DATA))
            st_q <= (seg_q + 4'h1 == segs_q) ? SVM_S_WAIT : SVM_S_PSI;
        default:
          st_q <= SVM_S_WAIT;
      endcase
    end
  end

  // Frame-level settings are frozen at each frame start
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      vc3_q  <= 1'b0;
      segs_q <= 4'h1;
      seg_q  <= 4'h0;
      idle_q <= 2'h0;
    end
    else if (sof_seen)
    begin
      vc3_q  <= i_src_vc3;
      segs_q <= (i_src_vc3 || (i_src_order == 4'h0)) ? 4'h1 : i_src_order;
      seg_q  <= 4'h0;
      idle_q <= (i_idle_count > `SVM_MAX_IDLE) ? `SVM_MAX_IDLE : i_idle_count;
    end
    else
    begin
      if ((st_q == SVM_S_JUST) && emit)
        idle_q <= idle_q - 2'h1;
      if ((st_q == SVM_S_DATA) && emit && (dcnt_q == `SVM_LAST_DATA))
        seg_q <= seg_q + 4'h1;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      cnt_q  <= 4'h0;
      dcnt_q <= 9'h000;
      acc_q  <= '0;
    end
    else
    begin
      if (restart || emit)
        cnt_q <= 4'h0;
      else if (acc_go && f_valid)
      begin
        cnt_q <= cnt_q + 4'h1;
        acc_q <= {acc_q[55:0], f_data.d};
      end
      if ((st_q == SVM_S_INIT) && emit)
        dcnt_q <= 9'h000;
      else if ((st_q == SVM_S_DATA) && emit)
        dcnt_q <= dcnt_q + 9'h001;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      slot_q <= '0;
      ov_q   <= 1'b0;
    end
    else if (emit)
    begin
      slot_q <= nslot;
      ov_q   <= 1'b1;
    end
    else if (i_slot_ready)
      ov_q <= 1'b0;
  end

  // Idles handed out since the last frame start, watched below
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst || sof_seen)
      ic_q <= 2'h0;
    else if ((st_q == SVM_S_JUST) && emit)
      ic_q <= ic_q + 2'h1;
  end

  assign o_adapted_slot_data = slot_q;
  assign o_slot_valid        = ov_q;
  assign o_idle_insert_strobe = ov_q && (slot_q.kind == SVM_K_IDLE);
  assign o_perf_supervision_insert_strobe = ov_q && (slot_q.kind == SVM_K_PS);
  assign o_frame_start_strobe = ov_q && (slot_q.kind == SVM_K_PS) && slot_q.fs;

  // Sink side
  logic [63:0] sh_q;
  logic [3:0]  rem_q;
  logic        first_q;
  logic        fsp_q;
  logic        lock_q;
  logic        exp_q;
  logic [8:0]  sdcnt_q;
  logic [23:0] align_q;
  logic [3:0]  sseg_q;
  logic        s_acc;
  logic        s_take;
  logic        s_init_ok;
  logic        s_data_ok;

  // One dead cycle per slot; the unpacker takes a slot only when empty
  assign o_sink_ready = (rem_q == 4'h0);
  assign s_acc        = i_sink_valid && o_sink_ready;
  assign s_take       = o_sink_octet_valid && i_sink_octet_ready;
  assign s_init_ok    = s_acc && (i_sink_slot.kind == SVM_K_INIT) && lock_q && exp_q;
  assign s_data_ok    = s_acc && (i_sink_slot.kind == SVM_K_DATA) && lock_q && !exp_q &&
                        (sdcnt_q < `SVM_DATA_SLOTS);

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      lock_q  <= 1'b0;
      exp_q   <= 1'b0;
      fsp_q   <= 1'b0;
      sdcnt_q <= 9'h000;
      align_q <= 24'h000000;
      sseg_q  <= 4'h0;
    end
    else if (s_acc && (i_sink_slot.kind == SVM_K_PS))
    begin
      lock_q <= 1'b1;
      exp_q  <= 1'b1;
      if (i_sink_slot.fs)
      begin
        fsp_q  <= 1'b1;
        sseg_q <= 4'h0;
      end
    end
    else if (s_init_ok)
    begin
      exp_q   <= 1'b0;
      fsp_q   <= 1'b0;
      sdcnt_q <= 9'h000;
      sseg_q  <= fsp_q ? 4'h0 : sseg_q + 4'h1;
      if (i_sink_vc3)
        align_q <= {16'h0000, i_sink_slot.data[63:56]};
      else
        align_q <= i_sink_slot.data[63:40];
    end
    else if (s_data_ok)
      sdcnt_q <= sdcnt_q + 9'h001;
  end

  // Idle slots are accepted and dropped with no count moving
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      sh_q    <= '0;
      rem_q   <= 4'h0;
      first_q <= 1'b0;
    end
    else if (s_init_ok)
    begin
      rem_q   <= svm_init_len(i_sink_vc3);
      first_q <= fsp_q;
      sh_q    <= i_sink_vc3 ? {i_sink_slot.data[55:0], 8'h00}
                            : {i_sink_slot.data[39:0], 24'h000000};
    end
    else if (s_data_ok)
    begin
      rem_q <= `SVM_SLOT_OCT;
      sh_q  <= i_sink_slot.data;
    end
    else if (s_take)
    begin
      rem_q   <= rem_q - 4'h1;
      sh_q    <= {sh_q[55:0], 8'h00};
      first_q <= 1'b0;
    end
  end

  assign o_sink_octet       = sh_q[63:56];
  assign o_sink_octet_valid = (rem_q != 4'h0);
  assign o_sink_frame_first = first_q && o_sink_octet_valid;
  assign o_sink_align       = align_q;
  assign o_sink_segment     = sseg_q;
  assign o_sink_locked      = lock_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_ps_out;
    emit && (st_q == SVM_S_PSI);
  endsequence
  sequence s_init_out;
    emit && (st_q == SVM_S_INIT);
  endsequence
  sequence s_last_data;
    emit && (st_q == SVM_S_DATA) && (dcnt_q == `SVM_LAST_DATA);
  endsequence

  property p_ps_then_init;
    s_ps_out |=> (st_q == SVM_S_INIT) && o_perf_supervision_insert_strobe;
  endproperty
  a_ps_then_init: assert property (p_ps_then_init) else $error("init not after marker");
  property p_init_len;
    s_init_out |-> (cnt_q == (vc3_q ? 4'h7 : 4'h5));
  endproperty
  a_init_len: assert property (p_init_len) else $error("initial slot octet count");
  property p_vc3_one;
    (st_q == SVM_S_DATA) && vc3_q |-> (segs_q == 4'h1);
  endproperty
  a_vc3_one: assert property (p_vc3_one) else $error("vc3 not single section");
  property p_data_eight;
    emit && (st_q == SVM_S_DATA) |-> (cnt_q == 4'h8);
  endproperty
  a_data_eight: assert property (p_data_eight) else $error("data slot octet count");
  property p_section_len;
    s_last_data |-> (dcnt_q == 9'h124) ##1 (st_q != SVM_S_DATA);
  endproperty
  a_section_len: assert property (p_section_len) else $error("section length wrong");
  property p_fs_strobe;
    s_ps_out |=> o_perf_supervision_insert_strobe &&
                 (o_frame_start_strobe == ($past(seg_q) == 4'h0));
  endproperty
  a_fs_strobe: assert property (p_fs_strobe) else $error("frame start off marker");
  property p_idle_limit;
    ic_q <= 2'h2;
  endproperty
  a_idle_limit: assert property (p_idle_limit) else $error("too many idle markers");
  property p_relock;
    sof_seen |=> (st_q == SVM_S_JUST) && (seg_q == 4'h0);
  endproperty
  a_relock: assert property (p_relock) else $error("segment count not restarted");
  property p_sink_idle;
    s_acc && (i_sink_slot.kind == SVM_K_IDLE) |=> $stable(sdcnt_q) && (rem_q == 4'h0);
  endproperty
  a_sink_idle: assert property (p_sink_idle) else $error("idle slot not dropped");
  property p_sink_data;
    s_data_ok |=> (rem_q == 4'h8) && (o_sink_octet == $past(i_sink_slot.data[63:56]));
  endproperty
  a_sink_data: assert property (p_sink_data) else $error("data slot unpack wrong");
endmodule
`default_nettype wire

/* File: src/svm_pkg.sv */
// Types of the VC section/slot mapper.
// Assumes the constants header is compiled alongside.
`default_nettype none
package svm_pkg;
  typedef enum logic [1:0] {
    SVM_K_DATA = 2'h0,
    SVM_K_INIT = 2'h1,
    SVM_K_PS   = 2'h2,
    SVM_K_IDLE = 2'h3
  } svm_kind_e;
  typedef struct packed {
    svm_kind_e   kind;
    logic        fs;
    logic [63:0] data;
  } svm_slot_s;
  typedef struct packed {
    logic       sof;
    logic [7:0] d;
  } svm_oct_s;
  typedef enum logic [4:0] {
    SVM_S_WAIT = 5'h01,
    SVM_S_JUST = 5'h02,
    SVM_S_PSI  = 5'h04,
    SVM_S_INIT = 5'h08,
    SVM_S_DATA = 5'h10
  } svm_src_e;
endpackage
`default_nettype wire
